// file: core/sac_map.vh
// constants for the serial converter control block
// assumes a 200 MHz system clock; included by bare name
`ifndef SAC_MAP_VH
`define SAC_MAP_VH

// ==========================================================
// clock and timing
`define SAC_CLK_NS 5
`define SAC_CONV_INT_NS 41000
`define SAC_CONV_INT_CYC ((`SAC_CONV_INT_NS) / (`SAC_CLK_NS))
`define SAC_CONV_INT_TICKS 11
`define SAC_CONV_EXT_TICKS 44
`define SAC_SAR_STEPS 10
`define SAC_BBM_CYC 4'h2

// ==========================================================
// serial framing
`define SAC_ADDR_BITS 4
`define SAC_RES_BITS 10
`define SAC_FALL_LAST_DATA 5'h08
`define SAC_FALL_START 5'h09
`define SAC_FALL_SAMPLE 5'h03
`define SAC_FALL_END 5'h0f
`define SAC_RISE_ADDR 5'h04
`define SAC_RISE_TENTH 5'h0a
`define SAC_CNT_MAX 5'h10
`define SAC_CNT_TEN 5'h0a

// ==========================================================
// address codes and self-test values
`define SAC_ADDR_LAST_CH 4'ha
`define SAC_ADDR_MID 4'hb
`define SAC_ADDR_LOW 4'hc
`define SAC_ADDR_HIGH 4'hd
`define SAC_VAL_MID 10'h200
`define SAC_VAL_LOW 10'h000
`define SAC_VAL_HIGH 10'h3ff

// ==========================================================
// input synchroniser bits: cs_b, sclk, din, conv clock, comparator
`define SAC_IN_CS 0
`define SAC_IN_SCLK 1
`define SAC_IN_DIN 2
`define SAC_IN_CCLK 3
`define SAC_IN_COMP 4
`define SAC_IN_RST 5'h01

`endif

// file: core/sac_sar.v
// successive-approximation register for the converter
// assumes start and step pulses on sys_clk, comparator already synced
`timescale 1ns/100ps
`default_nettype none
`include "sac_map.vh"

module sac_sar (
    // clock, reset, enable
    input wire sys_clk,
    input wire rst_b,
    input wire ce,
    // control
    input wire start,
    input wire step,
    input wire comp_ge,
    // trial word, final once all bits resolved
    output wire [9:0] trial
);

reg [9:0] trial_r;
reg [9:0] bit_r;

// ==========================================================
// one bit resolved per step, msb first
always @(posedge sys_clk) begin
    if (!rst_b) begin
        trial_r <= 10'h000;
        bit_r <= 10'h000;
    end else if (ce) begin
        if (start) begin
            trial_r <= `SAC_VAL_MID;
            bit_r <= `SAC_VAL_MID;
        end else if (step && (bit_r != 10'h000)) begin
            trial_r <= (comp_ge ? trial_r : (trial_r & ~bit_r)) |
                       (bit_r >> 1);
            bit_r <= bit_r >> 1;
        end
    end
end

assign trial = trial_r;

endmodule
`default_nettype wire

// file: core/sac_top.v
// serial port and conversion control of a 10-bit sar converter
// assumes host is serial master; pins asynchronous to sys_clk
`timescale 1ns/100ps
`default_nettype none
`include "sac_map.vh"

// Summary of operation
// - internal-oscillator variant drops conversion_done on tenth falling sclk.
// - internal variant raises conversion_done when the new result is ready; external variant holds it high.
// - addresses 0x0..0xa select analog inputs zero to ten.
// - 0xb, 0xc, 0xd select midpoint, lower and upper reference tests.
// - self-tests yield 0x200, 0x000 and 0x3ff without analog stimulus.
// - old input switch opens before the new one closes.
// - external-clock variant converts in exactly 44 conversion_clock cycles.
// - previous result shifts out while next address shifts in.
// - sixteen-clock transfers need the eleventh rising edge before conversion end.
// - in sixteen-bit format only four leading bits carry the address.
// - sixteen-bit result is ten data bits then six zeros.
// - sixteen-bit transfer may be one burst or two 8-clock bursts.
// - internal variant keeps a fixed cycle, independent of host clock.
// - addresses 0xe and 0xf are invalid and select nothing.
// - recognised chip-select fall resets and realigns the serial port.
// - result msb first, one bit per fall, low from the tenth fall.
// - address captured msb first on first four rising edges only.
module sac_top #(
    parameter INT_OSC = 1,
    parameter [15:0] CONV_INT_CYC = `SAC_CONV_INT_CYC
) (
    // clock, reset, enable
    input wire sys_clk,
    input wire rst_b,
    input wire ce,
    // serial port pins
    input wire cs_b,
    input wire sclk,
    input wire din,
    output wire dout,
    output wire dout_oe,
    // conversion clock and done flag
    input wire conversion_clock,
    output wire conversion_done,
    // analog front end
    input wire comp_above,
    output wire [10:0] analog_sel,
    output wire [2:0] test_sel,
    output wire sample_en,
    output wire [9:0] dac_trial,
    // last completed result
    output wire [9:0] result
);

localparam [1:0] ST_PORT = 2'd0;
localparam [1:0] ST_CONV = 2'd1;
localparam [15:0] INT_STEP = CONV_INT_CYC / 16'd`SAC_CONV_INT_TICKS;
localparam [5:0] LAST_TICK = INT_OSC ?
    6'd`SAC_CONV_INT_TICKS - 6'd1 : 6'd`SAC_CONV_EXT_TICKS - 6'd1;

// ==========================================================
// address decode to switch vector {tests, channels}
function [13:0] sel_dec;
    input [3:0] a;
    begin
        sel_dec = 14'h0000;
        if (a <= `SAC_ADDR_LAST_CH)
            sel_dec = 14'h0001 << a;
        else if (a <= `SAC_ADDR_HIGH)
            sel_dec = 14'h0001 << a;
    end
endfunction

// ==========================================================
// pin synchronisers, three stages, filtered on agreement
wire [4:0] in_raw = {comp_above, conversion_clock, din, sclk, cs_b};
wire [4:0] in_rst = `SAC_IN_RST;
reg [4:0] s1_r;
reg [4:0] s2_r;
reg [4:0] s3_r;
reg [4:0] filt_r;
wire [4:0] chg = ~(s2_r ^ s3_r) & (s3_r ^ filt_r);
wire [4:0] rise = chg & s3_r;
wire [4:0] fall = chg & ~s3_r;

genvar gi;
generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
        always @(posedge sys_clk) begin
            if (!rst_b) begin
                s1_r[gi] <= in_rst[gi];
                s2_r[gi] <= in_rst[gi];
                s3_r[gi] <= in_rst[gi];
                filt_r[gi] <= in_rst[gi];
            end else if (ce) begin
                s1_r[gi] <= in_raw[gi];
                s2_r[gi] <= s1_r[gi];
                s3_r[gi] <= s2_r[gi];
                if (s2_r[gi] == s3_r[gi])
                    filt_r[gi] <= s3_r[gi];
            end
        end
    end
endgenerate

wire cs_act = ~filt_r[`SAC_IN_CS];
wire cs_fall = fall[`SAC_IN_CS];
wire sclk_rise = rise[`SAC_IN_SCLK] & cs_act;
wire sclk_fall = fall[`SAC_IN_SCLK] & cs_act;

// ==========================================================
// state
reg [1:0] st_r;
reg [4:0] fall_cnt_r;
reg [4:0] rise_cnt_r;
reg [3:0] addr_r;
reg [3:0] conv_addr_r;
reg [9:0] shift_r;
reg dout_r;
reg done_r;
reg long_r;
reg samp_r;
reg [9:0] result_r;
reg [5:0] tick_cnt_r;
reg [15:0] sub_r;
reg sar_start_r;
reg [13:0] closed_r;
reg [3:0] gap_r;

wire int_tick = (sub_r == INT_STEP - 16'd1);
wire tick = (st_r == ST_CONV) &
    (INT_OSC ? int_tick : rise[`SAC_IN_CCLK]);
wire sar_step = tick & (tick_cnt_r < 6'd`SAC_SAR_STEPS);
wire conv_end = tick & (tick_cnt_r == LAST_TICK);
wire [9:0] sar_val;

// self-test compares against a fixed level, invalid address gives low, else the pin
wire [13:0] conv_dec = sel_dec(conv_addr_r);
reg comp_ge;
always @* begin
    comp_ge = filt_r[`SAC_IN_COMP];
    if (conv_dec[11])
        comp_ge = (`SAC_VAL_MID >= sar_val);
    else if (conv_dec[12])
        comp_ge = (`SAC_VAL_LOW >= sar_val);
    else if (conv_dec[13])
        comp_ge = (`SAC_VAL_HIGH >= sar_val);
    else if (conv_dec == 14'h0000)
        comp_ge = 1'b0;
end

sac_sar u_sar (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .ce(ce),
    .start(sar_start_r),
    .step(sar_step),
    .comp_ge(comp_ge),
    .trial(sar_val)
);

// ==========================================================
// serial port and conversion sequencer
always @(posedge sys_clk) begin
    if (!rst_b) begin
        st_r <= ST_PORT;
        fall_cnt_r <= 5'h00;
        rise_cnt_r <= 5'h00;
        addr_r <= 4'h0;
        conv_addr_r <= 4'h0;
        shift_r <= 10'h000;
        dout_r <= 1'b0;
        done_r <= 1'b1;
        long_r <= 1'b0;
        samp_r <= 1'b0;
        result_r <= 10'h000;
        tick_cnt_r <= 6'h00;
        sub_r <= 16'h0000;
        sar_start_r <= 1'b0;
    end else if (ce) begin
        sar_start_r <= 1'b0;
        if (cs_fall) begin
            st_r <= ST_PORT; // also aborts a conversion
            done_r <= 1'b1;
            fall_cnt_r <= 5'h00;
            rise_cnt_r <= 5'h00;
            shift_r <= result_r;
            dout_r <= result_r[9];
            long_r <= 1'b0;
            samp_r <= 1'b0;
        end else begin
            if (sclk_rise && rise_cnt_r < `SAC_CNT_MAX) begin
                rise_cnt_r <= rise_cnt_r + 5'h01;
                if (rise_cnt_r < `SAC_RISE_ADDR)
                    addr_r <= {addr_r[2:0], filt_r[`SAC_IN_DIN]};
                if (st_r == ST_CONV && rise_cnt_r == `SAC_RISE_TENTH)
                    long_r <= 1'b1;
            end
            if (sclk_fall && fall_cnt_r < `SAC_CNT_MAX) begin
                fall_cnt_r <= fall_cnt_r + 5'h01;
                if (fall_cnt_r < `SAC_FALL_LAST_DATA + 5'h01) begin
                    shift_r <= {shift_r[8:0], 1'b0};
                    dout_r <= shift_r[8];
                end else
                    dout_r <= 1'b0;
                if (fall_cnt_r == `SAC_FALL_SAMPLE)
                    samp_r <= 1'b1;
                if (st_r == ST_PORT && fall_cnt_r == `SAC_FALL_START) begin
                    st_r <= ST_CONV;
                    samp_r <= 1'b0;
                    done_r <= 1'b0;
                    conv_addr_r <= addr_r;
                    sar_start_r <= 1'b1;
                    tick_cnt_r <= 6'h00;
                    sub_r <= 16'h0000;
                end
                if (st_r == ST_PORT && fall_cnt_r == `SAC_FALL_END) begin
                    fall_cnt_r <= 5'h00; // long transfer ends
                    rise_cnt_r <= 5'h00;
                    shift_r <= result_r;
                    dout_r <= result_r[9];
                    long_r <= 1'b0;
                end
            end
            if (st_r == ST_CONV) begin
                sub_r <= int_tick ? 16'h0000 : sub_r + 16'h0001;
                if (tick)
                    tick_cnt_r <= tick_cnt_r + 6'h01;
                if (conv_end) begin
                    st_r <= ST_PORT;
                    result_r <= sar_val;
                    done_r <= 1'b1;
                    if ((fall_cnt_r == `SAC_CNT_TEN && !long_r) ||
                        fall_cnt_r == `SAC_CNT_MAX ||
                        (sclk_fall && fall_cnt_r == `SAC_FALL_END)) begin
                        fall_cnt_r <= 5'h00;
                        rise_cnt_r <= 5'h00;
                        shift_r <= sar_val;
                        dout_r <= sar_val[9];
                        long_r <= 1'b0;
                    end
                end
            end
        end
    end
end

// ==========================================================
// input switches, break before make
wire [3:0] mux_addr = (st_r == ST_PORT && rise_cnt_r >= `SAC_RISE_ADDR) ?
    addr_r : conv_addr_r;
wire [13:0] want = sel_dec(mux_addr);

always @(posedge sys_clk) begin
    if (!rst_b) begin
        closed_r <= 14'h0000;
        gap_r <= 4'h0;
    end else if (ce) begin
        if (closed_r != want) begin
            if (closed_r != 14'h0000) begin
                closed_r <= 14'h0000;
                gap_r <= `SAC_BBM_CYC;
            end else if (gap_r == 4'h0)
                closed_r <= want;
            else
                gap_r <= gap_r - 4'h1;
        end
    end
end

assign dout = dout_r;
assign dout_oe = cs_act;
assign conversion_done = INT_OSC ? done_r : 1'b1;
assign analog_sel = closed_r[10:0];
assign test_sel = closed_r[13:11];
assign sample_en = samp_r;
assign dac_trial = sar_val;
assign result = result_r;

endmodule
`default_nettype wire

// file: verification/sac_checker.sv
// port assertions for the converter control block
// assumes binding into sac_top, either variant
`timescale 1ns/100ps
`default_nettype none
module sac_checker #(
    parameter INT_OSC = 1,
    parameter [15:0] CONV_INT_CYC = 16'h2008
) (
    // clock and reset
    input wire sys_clk,
    input wire rst_b,
    // watched ports
    input wire cs_b,
    input wire dout,
    input wire dout_oe,
    input wire conversion_done,
    input wire [10:0] analog_sel,
    input wire [2:0] test_sel,
    input wire sample_en,
    input wire [9:0] result
);
    localparam int LEN = (CONV_INT_CYC / 11) * 11;
    logic [15:0] low_cnt;
    wire [13:0] sel = {analog_sel, test_sel};
    // ==========================================================
    // conversion length counter
    always @(posedge sys_clk) begin
        if (!rst_b || conversion_done)
            low_cnt <= 16'h0000;
        else
            low_cnt <= low_cnt + 16'h0001;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence conv_run;
        !conversion_done [*2];
    endsequence
    // ==========================================================
    // properties
    oe_idle_a: assert property (cs_b [*8] |-> !dout_oe)
        else $error("dout driven while deselected");
    dout_conv_a: assert property (conv_run |-> !dout)
        else $error("dout not low during conversion");
    dout_msb_a: assert property (
        $rose(dout_oe) |-> ##[0:2] (dout == result[9]))
        else $error("dout not msb at select");
    sel_single_a: assert property ($onehot0(sel))
        else $error("more than one switch closed");
    sel_gap_a: assert property (
        (|sel) && !$stable(sel) |-> $past(sel) == 14'h0000)
        else $error("switch closed without break");
    result_hold_a: assert property (
        !$stable(result) |->
            ##[0:1] ($rose(conversion_done) || INT_OSC == 0))
        else $error("result changed outside conversion end");
    conv_len_a: assert property (
        $rose(conversion_done) |-> low_cnt >= LEN - 2 && low_cnt <= LEN + 2)
        else $error("conversion length off");
    sample_done_a: assert property (sample_en |-> conversion_done)
        else $error("sampling during conversion");
    done_fall_a: assert property (
        $fell(conversion_done) |-> $past(sample_en))
        else $error("done fell outside tenth fall");
endmodule
bind sac_top sac_checker #(
    .INT_OSC(INT_OSC), .CONV_INT_CYC(CONV_INT_CYC)
) chk_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .cs_b(cs_b), .dout(dout),
    .dout_oe(dout_oe), .conversion_done(conversion_done),
    .analog_sel(analog_sel), .test_sel(test_sel),
    .sample_en(sample_en), .result(result)
);
`default_nettype wire

// file: verification/sac_host.sv
// host serial master model, drives the converter port
// assumes sys_clk 200 MHz; sclk period 160 ns
`timescale 1ns/100ps
`default_nettype none
module sac_host (
    // clock
    input wire logic sys_clk,
    // serial pins
    output logic cs_b,
    output logic sclk,
    output logic din,
    input wire logic dout,
    input wire logic dout_oe,
    // word read back
    output logic [15:0] rd_word,
    output logic rd_stb
);
    initial begin
        cs_b = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
        rd_word = 16'h0000;
        rd_stb = 1'b0;
    end
    task half;
        repeat (16) @(negedge sys_clk);
    endtask
    // n clocks; split pauses after the eighth
    task xfer(input logic [3:0] addr, input int n, input bit split);
        int k;
        cs_b <= 1'b0;
        rd_word <= 16'h0000;
        half();
        for (k = 0; k < n; k++) begin
            if (split && k == 8)
                repeat (4) half();
            din <= (k < 4) ? addr[3 - k] : 1'($urandom);
            half();
            sclk <= 1'b1;
            rd_word[15 - k] <= dout_oe ? dout : 1'bx;
            half();
            sclk <= 1'b0;
        end
        half();
        cs_b <= 1'b1;
        din <= ~din;
        rd_stb <= 1'b1;
        half();
        rd_stb <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// self-checking bench for the converter control block
// assumes sac_host model and bound checker
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic sys_clk, rst_b, comp_above, rd_stb;
    wire cs_b, sclk, din, dout, dout_oe, conversion_done, sample_en;
    wire [10:0] analog_sel;
    wire [2:0] test_sel;
    wire [9:0] dac_trial, result;
    wire [15:0] rd_word;
    logic [9:0] tgt [11];
    logic [9:0] held;
    logic [15:0] exp_q [$];
    logic conv_clk, ext_comp;
    wire ext_done;
    wire [9:0] ext_trial, ext_res;
    logic [15:0] ext_prev;
    logic [3:0] adr [10] = '{4'hb, 4'hc, 4'hd, 4'he, 4'h3,
                             4'h0, 4'ha, 4'h7, 4'h5, 4'h0};
    int mismatches = 0;
    int tests_run = 0;
    sac_top #(.INT_OSC(1), .CONV_INT_CYC(16'h006e)) dut_u (
        .sys_clk(sys_clk), .rst_b(rst_b), .ce(1'b1), .cs_b(cs_b),
        .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe),
        .conversion_clock(conv_clk), .conversion_done(conversion_done),
        .comp_above(comp_above), .analog_sel(analog_sel),
        .test_sel(test_sel), .sample_en(sample_en),
        .dac_trial(dac_trial), .result(result)
    );
    // external-clock variant on the same serial pins
    sac_top #(.INT_OSC(0)) ext_u (
        .sys_clk(sys_clk), .rst_b(rst_b), .ce(1'b1), .cs_b(cs_b),
        .sclk(sclk), .din(din), .dout(), .dout_oe(),
        .conversion_clock(conv_clk), .conversion_done(ext_done),
        .comp_above(ext_comp), .analog_sel(), .test_sel(),
        .sample_en(), .dac_trial(ext_trial), .result(ext_res)
    );
    always begin
        repeat (8) @(negedge sys_clk);
        conv_clk = ~conv_clk;
    end
    sac_host host_u (
        .sys_clk(sys_clk), .cs_b(cs_b), .sclk(sclk), .din(din),
        .dout(dout), .dout_oe(dout_oe), .rd_word(rd_word), .rd_stb(rd_stb)
    );
    // ==========================================================
    // analog model: sample and hold, comparator
    assign comp_above = (held >= dac_trial);
    assign ext_comp = (held >= ext_trial);
    always @(negedge sys_clk) begin
        if (sample_en) begin
            held <= 10'h000;
            for (int i = 0; i < 11; i++)
                if (analog_sel[i])
                    held <= tgt[i];
        end
    end
    always #2.5 sys_clk = ~sys_clk;
    // ==========================================================
    // checking
    task check(input string nm, input logic [15:0] seen,
               input logic [15:0] expd);
        tests_run++;
        if (seen !== expd) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, expd, seen);
        end
    endtask
    function automatic logic [15:0] expv(input logic [3:0] a);
        logic [9:0] v;
        v = 10'h000;
        if (a <= 4'ha)
            v = tgt[a];
        if (a == 4'hb)
            v = 10'h200;
        if (a == 4'hd)
            v = 10'h3ff;
        return {v, 6'h00};
    endfunction
    always @(posedge rd_stb) begin
        check("rd_word", 16'(rd_word), exp_q.pop_front());
    end
    task tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task wait_done;
        int c;
        c = 0;
        while (conversion_done !== 1'b1 && c < 400) begin
            @(negedge sys_clk);
            c++;
        end
        check("done", 16'(conversion_done), 16'h0001);
        repeat (20) @(negedge sys_clk);
    endtask
    // ==========================================================
    // main sequence: scan, read previous while sending next
    initial begin
        sys_clk = 1'b0;
        rst_b = 1'b0;
        held = 10'h000;
        conv_clk = 1'b0;
        ext_prev = 16'h0000;
        void'($urandom(32'h7f27));
        for (int i = 0; i < 11; i++)
            tgt[i] = 10'($urandom);
        repeat (4) @(negedge sys_clk);
        rst_b = 1'b1;
        for (int i = 0; i < 10; i++) begin
            exp_q.push_back(i == 0 ? 16'h0000 : expv(adr[i - 1]));
            host_u.xfer(adr[i], (i % 2) ? 16 : 10, i == 7);
            if (i % 2 == 0) begin
                check("done_low", 16'(conversion_done), 16'h0000);
                repeat (40) @(posedge conv_clk);
                check("ext_busy", 16'(ext_res), ext_prev);
                repeat (6) @(posedge conv_clk);
                check("ext_res", 16'(ext_res), expv(adr[i]) >> 6);
                check("ext_done", 16'(ext_done), 16'h0001);
            end
            wait_done();
            if (i % 2)
                repeat (48) @(posedge conv_clk);
            ext_prev = expv(adr[i]) >> 6;
            $display("test %0d done", i);
        end
        tally_and_finish();
    end
    initial begin
        #200000;
        mismatches++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
